// *** verilog/hmg_halt_ctrl.sv ***
// Overview of operation
// RL1 - halt on subsystem clock gates core clock
// RL2 - port latches hold their value during halt
// RL3 - 16-bit counters run only with main oscillator
// RL4 - main stopped: 8-bit counters need external input
// RL5 - main stopped: first interval timer needs counter A
// RL6 - second interval timer per oscillator combination
// RL7 - main stopped: watch timer needs subsystem clock
// RL8 - watchdog runs only if ring unstoppable
// RL9 - ring stopped means option allows and software stopped
// RL10 - main stopped: async ports need running counter A
// RL11 - main stopped: clocked ports need external clock
// RL12 - power-on-clear, voltage detect, external interrupts stay
// RL13 - main stopped: converter, auto port, multiplier stop
// RL14 - clock monitor stops when ring stopped
// RL15 - unmasked interrupt ends halt; masked keeps it
// RL16 - wait 8 clocks vectored, 2 otherwise
// RL17 - reset ends halt and fetches reset vector
//
// Added by the designer: the placing of the registers and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module hmg_halt_ctrl
  import hmg_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic mainOscRunPin,
  input wire logic maskRingStoppablePin,
  input wire logic maskPocUsedPin,
  input wire logic [IRQ_W-1:0] irqReq,
  output logic cpuClkEn,
  output logic haltActive,
  output logic [PORT_W-1:0] portOut,
  output logic [EN_W-1:0] periphEn,
  output logic vectorGo,
  output logic resumeGo,
  output logic resetVecGo
);
  typedef enum logic [1:0] {ST_RUN, ST_HALT, ST_WAKE} hmg_state_t;
  hmg_state_t state_reg;
  hmg_state_t state_next;
  logic [2:0] syncA_reg;
  logic [2:0] syncB_reg;
  logic [CTRL_W-1:0] ctrl_reg;
  logic [SEL_W-1:0] sel_reg;
  logic [IRQ_W-1:0] irqMask_reg;
  logic [PORT_W-1:0] port_reg;
  logic [31:0] rdata_reg;
  logic ready_reg;
  logic slverr_reg;
  logic cpuClkEn_reg;
  logic haltActive_reg;
  logic [EN_W-1:0] en_reg;
  logic vectorGo_reg;
  logic resumeGo_reg;
  logic resetVec_reg;
  logic vecSel_reg;
  logic mainRun;
  logic maskRing;
  logic maskPoc;
  logic ringStopped;
  logic wrEn;
  logic setupRd;
  logic haltCmd;
  logic wakeReq;
  logic wakeDone;
  logic mapped;
  logic [31:0] rdMux;

  hmg_gate_if gIf();

  // external pins are asynchronous to mclk
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      syncA_reg <= 3'h0;
      syncB_reg <= 3'h0;
    end else begin
      syncA_reg <= {maskPocUsedPin, maskRingStoppablePin, mainOscRunPin};
      syncB_reg <= syncA_reg;
    end
  end

  assign mainRun = syncB_reg[0];
  assign maskRing = syncB_reg[1];
  assign maskPoc = syncB_reg[2];
  assign ringStopped = maskRing & ctrl_reg[CTRL_RINGSTOP]; // RL9

  // apb: one wait-free access phase, pready raised by the setup cycle
  assign wrEn = psel & penable & ready_reg & pwrite;
  assign setupRd = psel & ~penable;
  assign haltCmd = wrEn && paddr == OFS_CMD && pwdata[CMD_HALT];

  always_comb begin
    mapped = 1'b1;
    rdMux = 32'h0000_0000;
    unique case (paddr)
      OFS_CTRL: rdMux[CTRL_W-1:0] = ctrl_reg;
      OFS_CLKSEL: rdMux[SEL_W-1:0] = sel_reg;
      OFS_IRQMASK: rdMux[IRQ_W-1:0] = irqMask_reg;
      OFS_PORT: rdMux[PORT_W-1:0] = port_reg;
      OFS_CMD: rdMux = 32'h0000_0000;
      OFS_STATUS: begin
        rdMux[STS_HALT] = state_reg == ST_HALT;
        rdMux[STS_WAKE] = state_reg == ST_WAKE;
        rdMux[STS_MAINRUN] = mainRun;
        rdMux[STS_RINGSTOP] = ringStopped;
        rdMux[STS_MASKRING] = maskRing;
        rdMux[STS_MASKPOC] = maskPoc;
      end
      OFS_ENABLE: rdMux[EN_W-1:0] = en_reg;
      default: mapped = 1'b0;
    endcase
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ready_reg <= 1'b0;
      slverr_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      ready_reg <= setupRd;
      slverr_reg <= setupRd & ~mapped;
      if (setupRd) begin
        rdata_reg <= pwrite ? 32'h0000_0000 : rdMux;
      end
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_reg <= CTRL_RST;
      sel_reg <= SEL_RST;
      irqMask_reg <= IRQMASK_RST;
    end else if (wrEn) begin
      if (paddr == OFS_CTRL) begin
        ctrl_reg <= pwdata[CTRL_W-1:0];
      end
      if (paddr == OFS_CLKSEL) begin
        sel_reg <= pwdata[SEL_W-1:0];
      end
      if (paddr == OFS_IRQMASK) begin
        irqMask_reg <= pwdata[IRQ_W-1:0];
      end
    end
  end

  // writes are dropped while halted so the latch keeps its pre-halt value
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      port_reg <= PORT_RST;
    end else if (wrEn && paddr == OFS_PORT && state_reg == ST_RUN) begin
      port_reg <= pwdata[PORT_W-1:0]; // RL2
    end
  end

  // halt sequencing
  assign wakeReq = |(irqReq & ~irqMask_reg); // RL15

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_RUN: begin
        if (haltCmd && ctrl_reg[CTRL_SUBCLK]) begin
          state_next = ST_HALT; // RL1
        end
      end
      ST_HALT: begin
        if (wakeReq) begin
          state_next = ST_WAKE; // RL15
        end
      end
      ST_WAKE: begin
        if (wakeDone) begin
          state_next = ST_RUN; // RL16
        end
      end
    endcase
  end

  // reset forces run state whatever halt status was
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= ST_RUN; // RL17
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      vecSel_reg <= 1'b0;
    end else if (state_reg == ST_HALT && wakeReq) begin
      vecSel_reg <= ctrl_reg[CTRL_IE]; // RL15
    end
  end

  hmg_release uRelease (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .start(state_reg == ST_HALT && wakeReq),
    .waitLen(ctrl_reg[CTRL_IE] ? WAIT_VEC : WAIT_NEXT), // RL16
    .done(wakeDone)
  );

  // core clock stays off through the release wait as well
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cpuClkEn_reg <= 1'b1;
      haltActive_reg <= 1'b0;
    end else begin
      cpuClkEn_reg <= state_next == ST_RUN; // RL1
      haltActive_reg <= state_next != ST_RUN; // RL1
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      vectorGo_reg <= 1'b0;
      resumeGo_reg <= 1'b0;
    end else begin
      vectorGo_reg <= state_reg == ST_WAKE && wakeDone && vecSel_reg;
      resumeGo_reg <= state_reg == ST_WAKE && wakeDone && !vecSel_reg;
    end
  end

  // high through reset, cleared by the first clock after release
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      resetVec_reg <= 1'b1; // RL17
    end else begin
      resetVec_reg <= 1'b0;
    end
  end

  assign gIf.inHalt = state_reg != ST_RUN;
  assign gIf.mainRun = mainRun;
  assign gIf.ringStopped = ringStopped;
  assign gIf.maskRingStoppable = maskRing;
  assign gIf.maskPocUsed = maskPoc;
  assign gIf.sel = sel_reg;

  hmg_gate uGate (
    .g(gIf)
  );

  // registered so enables never glitch on select changes
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      en_reg <= '1;
    end else begin
      en_reg <= gIf.en;
    end
  end

  assign prdata = rdata_reg;
  assign pready = ready_reg;
  assign pslverr = slverr_reg;
  assign cpuClkEn = cpuClkEn_reg;
  assign haltActive = haltActive_reg;
  assign portOut = port_reg;
  assign periphEn = en_reg;
  assign vectorGo = vectorGo_reg;
  assign resumeGo = resumeGo_reg;
  assign resetVecGo = resetVec_reg;
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  property p_core_gated;
    state_reg != ST_RUN |-> !cpuClkEn_reg && haltActive_reg;
  endproperty
  a_core_gated: assert property (p_core_gated) // RL1
    else $error("core clock running during halt");
  property p_port_hold;
    state_reg != ST_RUN && $past(state_reg) != ST_RUN |-> $stable(port_reg);
  endproperty
  a_port_hold: assert property (p_port_hold) // RL2
    else $error("port latch changed in halt");
  property p_tm16_stop;
    gIf.inHalt && !mainRun |-> gIf.en[EN_TM16 +: 2] == 2'h0;
  endproperty
  a_tm16_stop: assert property (p_tm16_stop) // RL3
    else $error("16-bit counter enabled without main oscillator");
  property p_cnta_ext;
    gIf.inHalt && !mainRun |-> gIf.en[EN_TM8] == sel_reg[SEL_CNTA_EXT];
  endproperty
  a_cnta_ext: assert property (p_cnta_ext) // RL4
    else $error("counter A enable wrong with main stopped");
  property p_wdt;
    gIf.inHalt |-> gIf.en[EN_WDT] == !maskRing;
  endproperty
  a_wdt: assert property (p_wdt) // RL8
    else $error("watchdog enable wrong in halt");
  property p_ring_stop;
    gIf.inHalt && !maskRing |-> !ringStopped && gIf.en[EN_CLKMON];
  endproperty
  a_ring_stop: assert property (p_ring_stop) // RL9
    else $error("ring counted stopped without option and software");
  property p_its_both_stop;
    gIf.inHalt && !mainRun && ringStopped |-> !gIf.en[EN_ITS];
  endproperty
  a_its_both_stop: assert property (p_its_both_stop) // RL6
    else $error("second interval timer running with both stopped");
  property p_main_units;
    gIf.inHalt && !mainRun |->
      !gIf.en[EN_ADC] && !gIf.en[EN_AUTO] && !gIf.en[EN_MULDIV];
  endproperty
  a_main_units: assert property (p_main_units) // RL13
    else $error("main-clock unit enabled with main stopped");
  property p_masked_hold;
    state_reg == ST_HALT && !wakeReq |=> state_reg == ST_HALT;
  endproperty
  a_masked_hold: assert property (p_masked_hold) // RL15
    else $error("halt left without unmasked request");
  property p_vec_wait;
    state_reg == ST_HALT && wakeReq && ctrl_reg[CTRL_IE] |->
      ##9 vectorGo_reg && cpuClkEn_reg;
  endproperty
  a_vec_wait: assert property (p_vec_wait) // RL16
    else $error("vectored release wait not 8 clocks");
  property p_next_wait;
    state_reg == ST_HALT && wakeReq && !ctrl_reg[CTRL_IE] |->
      !cpuClkEn_reg [*3] ##1 resumeGo_reg && cpuClkEn_reg;
  endproperty
  a_next_wait: assert property (p_next_wait) // RL16
    else $error("plain release wait not 2 clocks");
  property p_clkmon;
    gIf.inHalt |-> gIf.en[EN_CLKMON] == !ringStopped;
  endproperty
  a_clkmon: assert property (p_clkmon) // RL14
    else $error("clock monitor enable wrong in halt");
endmodule
`default_nettype wire

// *** verilog/hmg_pkg.sv ***
`default_nettype none
package hmg_pkg;
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CLKSEL = 8'h04;
  localparam logic [7:0] OFS_IRQMASK = 8'h08;
  localparam logic [7:0] OFS_PORT = 8'h0C;
  localparam logic [7:0] OFS_CMD = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_ENABLE = 8'h18;
  localparam int CTRL_W = 3;
  localparam int CTRL_SUBCLK = 0;
  localparam int CTRL_RINGSTOP = 1;
  localparam int CTRL_IE = 2;
  localparam logic [CTRL_W-1:0] CTRL_RST = 3'h0;
  localparam int SEL_W = 10;
  localparam int SEL_CNTA_EXT = 0;
  localparam int SEL_CNTB_EXT = 1;
  localparam int SEL_ITF_CNTA = 2;
  localparam int SEL_ITS_LSB = 3;
  localparam int SEL_WATCH_SUB = 5;
  localparam int SEL_ASYNC_LSB = 6;
  localparam int SEL_CLKD_LSB = 8;
  localparam logic [SEL_W-1:0] SEL_RST = 10'h000;
  localparam logic [1:0] ITS_MAIN = 2'h0;
  localparam logic [1:0] ITS_FS7 = 2'h1;
  localparam int IRQ_W = 8;
  localparam logic [IRQ_W-1:0] IRQMASK_RST = 8'hFF;
  localparam int PORT_W = 8;
  localparam logic [PORT_W-1:0] PORT_RST = 8'h00;
  localparam int CMD_HALT = 0;
  localparam int STS_HALT = 0;
  localparam int STS_WAKE = 1;
  localparam int STS_MAINRUN = 2;
  localparam int STS_RINGSTOP = 3;
  localparam int STS_MASKRING = 4;
  localparam int STS_MASKPOC = 5;
  localparam int EN_W = 19;
  localparam int EN_TM16 = 0;
  localparam int EN_TM8 = 2;
  localparam int EN_ITF = 4;
  localparam int EN_ITS = 5;
  localparam int EN_WATCH = 6;
  localparam int EN_WDT = 7;
  localparam int EN_ASYNC = 8;
  localparam int EN_CLKD = 10;
  localparam int EN_ADC = 12;
  localparam int EN_AUTO = 13;
  localparam int EN_MULDIV = 14;
  localparam int EN_CLKMON = 15;
  localparam int EN_POC = 16;
  localparam int EN_LVD = 17;
  localparam int EN_EXTINT = 18;
  localparam int WAIT_W = 4;
  localparam logic [WAIT_W-1:0] WAIT_VEC = 4'h8;
  localparam logic [WAIT_W-1:0] WAIT_NEXT = 4'h2;
endpackage
`default_nettype wire

// *** verilog/hmg_gate_if.sv ***
`timescale 1ns/100ps
`default_nettype none
interface hmg_gate_if;
  import hmg_pkg::*;
  logic inHalt;
  logic mainRun;
  logic ringStopped;
  logic maskRingStoppable;
  logic maskPocUsed;
  logic [SEL_W-1:0] sel;
  logic [EN_W-1:0] en;
  modport ctrl(output inHalt, mainRun, ringStopped, maskRingStoppable,
    maskPocUsed, sel, input en);
  modport gate(input inHalt, mainRun, ringStopped, maskRingStoppable,
    maskPocUsed, sel, output en);
endinterface
`default_nettype wire

// *** verilog/hmg_gate.sv ***
`timescale 1ns/100ps
`default_nettype none
module hmg_gate
  import hmg_pkg::*;
(
  hmg_gate_if.gate g
);
  logic cntARun;
  logic [1:0] itsSel;
  always_comb begin
    cntARun = g.mainRun | g.sel[SEL_CNTA_EXT];
    itsSel = g.sel[SEL_ITS_LSB +: 2];
    g.en = '1;
    g.en[EN_POC] = g.maskPocUsed; // RL12
    g.en[EN_LVD] = 1'b1; // RL12
    g.en[EN_EXTINT] = 1'b1; // RL12
    if (g.inHalt) begin
      g.en[EN_TM16 +: 2] = {2{g.mainRun}}; // RL3
      g.en[EN_TM8] = cntARun; // RL4
      g.en[EN_TM8+1] = g.mainRun | g.sel[SEL_CNTB_EXT]; // RL4
      g.en[EN_ITF] = g.mainRun | (g.sel[SEL_ITF_CNTA] & cntARun); // RL5
      if (g.mainRun) begin
        g.en[EN_ITS] = !g.ringStopped || itsSel == ITS_MAIN; // RL6
      end else begin
        g.en[EN_ITS] = !g.ringStopped && itsSel == ITS_FS7; // RL6
      end
      g.en[EN_WATCH] = g.mainRun | g.sel[SEL_WATCH_SUB]; // RL7
      g.en[EN_WDT] = !g.maskRingStoppable; // RL8
      for (int i = 0; i < 2; i++) begin
        g.en[EN_ASYNC+i] = g.mainRun |
          (g.sel[SEL_ASYNC_LSB+i] & cntARun); // RL10
        g.en[EN_CLKD+i] = g.mainRun | g.sel[SEL_CLKD_LSB+i]; // RL11
      end
      g.en[EN_ADC] = g.mainRun; // RL13
      g.en[EN_AUTO] = g.mainRun; // RL13
      g.en[EN_MULDIV] = g.mainRun; // RL13
      g.en[EN_CLKMON] = !g.ringStopped; // RL14
    end
  end
endmodule
`default_nettype wire

// *** verilog/hmg_release.sv ***
`timescale 1ns/100ps
`default_nettype none
module hmg_release
  import hmg_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic start,
  input wire logic [WAIT_W-1:0] waitLen,
  output logic done
);
  logic [WAIT_W-1:0] cnt_reg;
  // counts down the post-release wait; done marks its last cycle
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_reg <= '0;
    end else if (start) begin
      cnt_reg <= waitLen; // RL16
    end else if (cnt_reg != '0) begin
      cnt_reg <= cnt_reg - 1'b1;
    end
  end
  assign done = (cnt_reg == 4'h1) && !start;
endmodule
`default_nettype wire

// *** dv/hmg_irq_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module hmg_irq_model
  import hmg_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [IRQ_W-1:0] raise,
  input wire logic vectorGo,
  input wire logic resumeGo,
  output logic [IRQ_W-1:0] irqReq
);
  // sources hold their request as a level until the core restarts,
  // as real peripherals keep their request flag set until serviced
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      irqReq <= 8'h00;
    end else if (vectorGo || resumeGo) begin
      irqReq <= 8'h00;
    end else begin
      irqReq <= irqReq | raise;
    end
  end
endmodule
`default_nettype wire

// *** dv/test_halt_mode_subclock_peripheral_gating.sv ***
`timescale 1ns/100ps
`default_nettype none
module test_halt_mode_subclock_peripheral_gating
  import hmg_pkg::*;
;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, cpuClkEn, haltActive;
  logic vectorGo, resumeGo, resetVecGo;
  logic mainOscRunPin = 1'b1;
  logic maskRingStoppablePin = 1'b0;
  logic maskPocUsedPin = 1'b0;
  logic [IRQ_W-1:0] irqReq;
  logic [IRQ_W-1:0] raise = 8'h00;
  logic [PORT_W-1:0] portOut;
  logic [EN_W-1:0] periphEn;
  logic [31:0] rd;
  logic rerr;
  int failures = 0;
  int total_checks = 0;
  int cycles = 0;
  logic [SEL_W-1:0] sels [3] = '{10'h000, 10'h3EF, 10'h2D6};

  always #10 mclk = ~mclk;

  hmg_halt_ctrl hmg_halt_ctrl_inst (.mclk(mclk), .sys_rst(sys_rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mainOscRunPin(mainOscRunPin),
    .maskRingStoppablePin(maskRingStoppablePin),
    .maskPocUsedPin(maskPocUsedPin), .irqReq(irqReq),
    .cpuClkEn(cpuClkEn), .haltActive(haltActive), .portOut(portOut),
    .periphEn(periphEn), .vectorGo(vectorGo), .resumeGo(resumeGo),
    .resetVecGo(resetVecGo));

  hmg_irq_model hmg_irq_model_inst (.mclk(mclk), .sys_rst(sys_rst),
    .raise(raise), .vectorGo(vectorGo), .resumeGo(resumeGo),
    .irqReq(irqReq));

  task conclude;
    $display("checks=%0d failures=%0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // generous ceiling: the full run needs about one thousand cycles
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      conclude;
    end
  end

  task check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // entered just after a rising edge; idle cycle at the end
  task apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    // only the global cycle ceiling ends this wait
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rd = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask

  task rdchk(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask

  function automatic logic [EN_W-1:0] expEn(input logic m, input logic rs,
    input logic mr, input logic mp, input logic [SEL_W-1:0] s);
    logic a;
    logic [1:0] its;
    logic [EN_W-1:0] e;
    a = m | s[SEL_CNTA_EXT];
    its = s[SEL_ITS_LSB +: 2];
    e = 19'h7FFFF;
    e[EN_TM16] = m;
    e[EN_TM16+1] = m;
    e[EN_TM8] = a;
    e[EN_TM8+1] = m | s[SEL_CNTB_EXT];
    e[EN_ITF] = m | (s[SEL_ITF_CNTA] & a);
    e[EN_ITS] = m ? (!rs || its == ITS_MAIN) : (!rs && its == ITS_FS7);
    e[EN_WATCH] = m | s[SEL_WATCH_SUB];
    e[EN_WDT] = !mr;
    e[EN_ASYNC] = m | (s[SEL_ASYNC_LSB] & a);
    e[EN_ASYNC+1] = m | (s[SEL_ASYNC_LSB+1] & a);
    e[EN_CLKD] = m | s[SEL_CLKD_LSB];
    e[EN_CLKD+1] = m | s[SEL_CLKD_LSB+1];
    e[EN_ADC] = m;
    e[EN_AUTO] = m;
    e[EN_MULDIV] = m;
    e[EN_CLKMON] = !rs;
    e[EN_POC] = mp;
    return e;
  endfunction

  task t_reset;
    check(cpuClkEn, 32'h1);
    check(periphEn, 32'h6FFFF);
    rdchk(OFS_CTRL, 32'h0);
    rdchk(OFS_CLKSEL, 32'h0);
    rdchk(OFS_IRQMASK, 32'hFF);
    rdchk(OFS_PORT, 32'h0);
    rdchk(OFS_CMD, 32'h0);
    rdchk(OFS_STATUS, 32'h4);
    rdchk(8'h1C, 32'h0);
    check(rerr, 32'h1);
  endtask

  task t_refuse;
    apb(1'b1, OFS_CTRL, 32'h0);
    apb(1'b1, OFS_CMD, 32'h1);
    check(haltActive, 32'h0);
    check(cpuClkEn, 32'h1);
  endtask

  task t_halt(input logic m, input int rm, input logic [SEL_W-1:0] s);
    int n;
    logic rs;
    rs = (rm == 2);
    mainOscRunPin <= m;
    maskRingStoppablePin <= (rm != 0);
    maskPocUsedPin <= m;
    repeat (4) @(posedge mclk);
    // rm 0 sets the software stop bit too, which the option must override
    apb(1'b1, OFS_CTRL, {29'h0, m, rm != 1, 1'b1});
    apb(1'b1, OFS_CLKSEL, {22'h0, s});
    apb(1'b1, OFS_IRQMASK, 32'hFE);
    apb(1'b1, OFS_PORT, 32'h5A);
    apb(1'b1, OFS_CMD, 32'h1);
    check(haltActive, 32'h1);
    check(cpuClkEn, 32'h0);
    apb(1'b1, OFS_PORT, 32'hA5);
    check(portOut, 32'h5A);
    check(periphEn, expEn(m, rs, rm != 0, m, s));
    rdchk(OFS_ENABLE, expEn(m, rs, rm != 0, m, s));
    rdchk(OFS_STATUS, {26'h0, m, rm != 0, rs, m, 2'h1});
    raise <= 8'h02;
    @(posedge mclk);
    raise <= 8'h00;
    repeat (12) @(posedge mclk);
    check(haltActive, 32'h1);
    check(periphEn, expEn(m, rs, rm != 0, m, s));
    raise <= 8'h01;
    n = 0;
    do begin
      @(posedge mclk);
      raise <= 8'h00;
      n++;
    end while (vectorGo !== 1'b1 && resumeGo !== 1'b1);
    // source latch, taking edge and pulse edge add three to the wait
    check(n, 32'(m ? WAIT_VEC : WAIT_NEXT) + 32'd3);
    check(vectorGo, m);
    check(resumeGo, !m);
    check(cpuClkEn, 32'h1);
    check(haltActive, 32'h0);
    @(posedge mclk);
    rdchk(OFS_ENABLE, {2'h3, m, 16'hFFFF});
  endtask

  task t_rst_halt;
    apb(1'b1, OFS_CTRL, 32'h1);
    apb(1'b1, OFS_CMD, 32'h1);
    check(haltActive, 32'h1);
    sys_rst <= 1'b1;
    repeat (3) @(posedge mclk);
    check(haltActive, 32'h0);
    check(cpuClkEn, 32'h1);
    check(resetVecGo, 32'h1);
    check(portOut, 32'h0);
    sys_rst <= 1'b0;
    repeat (3) @(posedge mclk);
    check(resetVecGo, 32'h0);
  endtask

  initial begin
    repeat (20) @(posedge mclk);
    check(resetVecGo, 32'h1);
    sys_rst <= 1'b0;
    repeat (3) @(posedge mclk);
    check(resetVecGo, 32'h0);
    t_reset;
    t_refuse;
    for (int m = 0; m < 2; m++) begin
      for (int rm = 0; rm < 3; rm++) begin
        for (int si = 0; si < 3; si++) begin
          t_halt(m[0], rm, sels[si]);
        end
      end
    end
    t_rst_halt;
    conclude;
  end
endmodule
`default_nettype wire
